// file: hw/pucfg_top.v
// position-unit resolution configuration with an ahb-lite register slave
// Function
// - resolution means position steps per motor turn; scales all travel
// - unit code 1: resolution equals numerator divided by denominator
// - valid resolution 500 to 36000 inclusive; reset value 36000
// - unit information flag high while computed resolution out of range
// - power-up or configure with information flag raises unit error alarm
// - gearbox or mechanism codes derive resolution ignoring numerator/denominator
// - motor direction 0: positive is clockwise; 1 reverses it
// - gear ratio is gear numerator over gear denominator
// - codes 23..26: resolution is one over unit times inverse gear ratio
// - codes 31..34: resolution is 360 over unit times inverse gear ratio
// - gearbox direction is motor inversion xor gear inversion
// - code 0 prefers encoder setting, else numerator/denominator
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module pucfg_top (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output wire [31:0] hrdata,
	input  wire        mech_present,
	input  wire [23:0] mech_res,
	output wire [15:0] active_res,
	output wire        positive_direction_ccw,
	output wire        unit_info,
	output wire        unit_alarm,
	output wire        irq
);
`include "pucfg_defs.vh"

//////////////////////////////////////////////////////////////////////
// declarations
reg  [7:0]  unit_q;
reg  [15:0] res_num_q;
reg  [15:0] res_den_q;
reg  [15:0] gear_num_q;
reg  [15:0] gear_den_q;
reg  [1:0]  dir_q;
reg  [15:0] res_act_q;
reg         dir_act_q;
reg         alarm_q;
reg         calc_pend_q;
reg         apply_q;
reg         div_start_q;
reg  [2:0]  irq_stat_q;
reg  [2:0]  irq_stat_d;
reg  [2:0]  irq_mask_q;
reg         info_prev_q;
reg         mech_s1_q;
reg         mech_s2_q;
reg         mech_s3_q;
reg         wr_pend_q;
reg  [7:0]  wr_addr_q;
reg  [31:0] hrdata_q;
reg  [31:0] rd_mux;
reg  [23:0] scale;
reg  [39:0] num_w;
reg  [15:0] den_w;
reg         code_ok;
reg         geared;
wire        addr_ph;
wire        wr_en;
wire        param_wr;
wire        cfg_cmd;
wire        alm_clr;
wire [39:0] lo_lim;
wire [39:0] hi_lim;
wire        info;
wire        div_busy;
wire [39:0] div_quo;
wire        apply_now;
wire        raise_alarm;
wire        dir_eff;
wire        use_mech;

//////////////////////////////////////////////////////////////////////
// ahb-lite slave: zero wait state, always okay
assign addr_ph   = hsel & htrans[1] & hready;
assign hreadyout = 1'b1;
assign hresp     = 1'b0;
assign hrdata    = hrdata_q;
assign wr_en     = wr_pend_q;

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		wr_pend_q <= 1'b0;
		wr_addr_q <= 8'h00;
		hrdata_q  <= 32'h0;
	end else begin
		wr_pend_q <= addr_ph & hwrite;
		if (addr_ph) begin
			wr_addr_q <= haddr;
		end
		if (addr_ph & !hwrite) begin
			hrdata_q <= rd_mux;
		end
	end
end

assign param_wr = wr_en & ((wr_addr_q == `PU_OFF_UNIT) | (wr_addr_q == `PU_OFF_RES_NUM) |
	(wr_addr_q == `PU_OFF_RES_DEN) | (wr_addr_q == `PU_OFF_GEAR_NUM) |
	(wr_addr_q == `PU_OFF_GEAR_DEN));
assign cfg_cmd  = wr_en & (wr_addr_q == `PU_OFF_CTRL) & hwdata[`PU_CTRL_CONFIG];
assign alm_clr  = wr_en & (wr_addr_q == `PU_OFF_CTRL) & hwdata[`PU_CTRL_ALM_CLR];

//////////////////////////////////////////////////////////////////////
// parameter registers
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		unit_q     <= `PU_RST_UNIT;
		res_num_q  <= `PU_RST_RES;
		res_den_q  <= `PU_RST_DEN;
		gear_num_q <= `PU_RST_DEN;
		gear_den_q <= `PU_RST_DEN;
		dir_q      <= 2'h0;
		irq_mask_q <= 3'h0;
	end else if (wr_en) begin
		case (wr_addr_q)
		`PU_OFF_UNIT:     unit_q     <= hwdata[7:0];
		`PU_OFF_RES_NUM:  res_num_q  <= hwdata[15:0];
		`PU_OFF_RES_DEN:  res_den_q  <= hwdata[15:0];
		`PU_OFF_GEAR_NUM: gear_num_q <= hwdata[15:0];
		`PU_OFF_GEAR_DEN: gear_den_q <= hwdata[15:0];
		`PU_OFF_DIR:      dir_q      <= hwdata[1:0];
		`PU_OFF_IRQ_MASK: irq_mask_q <= hwdata[`PU_IRQ_W-1:0];
		default:          dir_q      <= dir_q;
		endcase
	end
end

//////////////////////////////////////////////////////////////////////
// mechanism presence pin synchroniser
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		mech_s1_q <= 1'b0;
		mech_s2_q <= 1'b0;
		mech_s3_q <= 1'b0;
	end else begin
		mech_s1_q <= mech_present;
		mech_s2_q <= mech_s1_q;
		// third stage marks a level change in step with the recompute request
		mech_s3_q <= mech_s2_q;
	end
end

assign use_mech = ((unit_q == `PU_UNIT_ENC) & mech_s3_q) |
	((unit_q >= `PU_UNIT_MECH1) & (unit_q <= `PU_UNIT_MECH4));

//////////////////////////////////////////////////////////////////////
// resolution as an exact fraction num_w / den_w
always @* begin
	scale   = 24'h0;
	num_w   = 40'h0;
	den_w   = 16'h0;
	code_ok = 1'b1;
	geared  = 1'b1;
	case (unit_q)
	8'd23: scale = 24'd1000;
	8'd24: scale = 24'd10000;
	8'd25: scale = 24'd100000;
	8'd26: scale = 24'd1000000;
	8'd31: scale = `PU_DEG_TURN * 24'd10;
	8'd32: scale = `PU_DEG_TURN * 24'd100;
	8'd33: scale = `PU_DEG_TURN * 24'd1000;
	8'd34: scale = `PU_DEG_TURN * 24'd10000;
	default: scale = mech_res;
	endcase
	if (use_mech) begin
		num_w = scale * {24'h0, gear_den_q};
		den_w = gear_num_q;
	end else if ((unit_q == `PU_UNIT_STEP) | (unit_q == `PU_UNIT_ENC)) begin
		num_w  = {24'h0, res_num_q};
		den_w  = res_den_q;
		geared = 1'b0;
	end else if (((unit_q >= `PU_UNIT_REV3) & (unit_q <= `PU_UNIT_REV6)) |
		((unit_q >= `PU_UNIT_DEG1) & (unit_q <= `PU_UNIT_DEG4))) begin
		// inverse unit divided by gear ratio
		num_w = scale * {24'h0, gear_den_q};
		den_w = gear_num_q;
	end else begin
		code_ok = 1'b0;
		den_w   = 16'h1;
	end
end

assign lo_lim = {24'h0, den_w} * `PU_RES_MIN;
assign hi_lim = {24'h0, den_w} * `PU_RES_MAX;
// out of range or unusable setting
assign info   = !code_ok | (den_w == 16'h0) | (num_w < lo_lim) | (num_w > hi_lim);

//////////////////////////////////////////////////////////////////////
// recompute the integer resolution after every unit, resolution or gear write and on a mechanism pin change
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		calc_pend_q <= 1'b1;
		div_start_q <= 1'b0;
	end else begin
		div_start_q <= 1'b0;
		if (param_wr | (mech_s3_q != mech_s2_q)) begin
			calc_pend_q <= 1'b1;
		end else if (calc_pend_q & !div_busy & !div_start_q) begin
			calc_pend_q <= 1'b0;
			div_start_q <= 1'b1;
		end
	end
end

pucfg_div u_div (
	.hclk     (hclk),
	.hresetn  (hresetn),
	.start    (div_start_q),
	.dividend (num_w),
	.divisor  ((den_w == 16'h0) ? 16'h1 : den_w),
	.busy     (div_busy),
	.quotient (div_quo)
);

//////////////////////////////////////////////////////////////////////
// apply at configure or power-up
// direction sign
assign dir_eff     = geared ? (dir_q[`PU_DIR_MOTOR] ^ dir_q[`PU_DIR_GEAR]) : dir_q[`PU_DIR_MOTOR];
assign apply_now   = apply_q & !calc_pend_q & !div_busy & !div_start_q & !param_wr;
assign raise_alarm = apply_now & info;

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		apply_q   <= 1'b1;
		res_act_q <= `PU_RST_RES;
		dir_act_q <= 1'b0;
		alarm_q   <= 1'b0;
	end else begin
		if (cfg_cmd) begin
			apply_q <= 1'b1;
		end else if (apply_now) begin
			apply_q <= 1'b0;
		end
		if (apply_now & !info) begin
			res_act_q <= div_quo[15:0];
			dir_act_q <= dir_eff;
		end
		if (raise_alarm) begin
			alarm_q <= 1'b1;
		end else if (alm_clr) begin
			alarm_q <= 1'b0;
		end
	end
end

assign active_res             = res_act_q;
assign positive_direction_ccw = dir_act_q;
assign unit_info              = info;
assign unit_alarm             = alarm_q;

//////////////////////////////////////////////////////////////////////
// interrupts: sticky, write one to clear, set wins
always @* begin
	irq_stat_d = irq_stat_q;
	if (wr_en & (wr_addr_q == `PU_OFF_IRQ_STAT)) begin
		irq_stat_d = irq_stat_q & ~hwdata[`PU_IRQ_W-1:0];
	end
	irq_stat_d[`PU_IRQ_INFO]    = irq_stat_d[`PU_IRQ_INFO] | (info & !info_prev_q);
	irq_stat_d[`PU_IRQ_ALARM]   = irq_stat_d[`PU_IRQ_ALARM] | raise_alarm;
	irq_stat_d[`PU_IRQ_APPLIED] = irq_stat_d[`PU_IRQ_APPLIED] | (apply_now & !info);
end

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		irq_stat_q  <= 3'h0;
		info_prev_q <= 1'b0;
	end else begin
		irq_stat_q  <= irq_stat_d;
		info_prev_q <= info;
	end
end

assign irq = |(irq_stat_q & irq_mask_q);

//////////////////////////////////////////////////////////////////////
// read multiplexer
always @* begin
	rd_mux = 32'h0;
	case (haddr)
	`PU_OFF_UNIT:     rd_mux = {24'h0, unit_q};
	`PU_OFF_RES_NUM:  rd_mux = {16'h0, res_num_q};
	`PU_OFF_RES_DEN:  rd_mux = {16'h0, res_den_q};
	`PU_OFF_GEAR_NUM: rd_mux = {16'h0, gear_num_q};
	`PU_OFF_GEAR_DEN: rd_mux = {16'h0, gear_den_q};
	`PU_OFF_DIR:      rd_mux = {30'h0, dir_q};
	`PU_OFF_STATUS:   rd_mux = {27'h0, apply_q, dir_act_q, calc_pend_q | div_busy | div_start_q,
		alarm_q, info};
	`PU_OFF_RES_ACT:  rd_mux = {16'h0, res_act_q};
	`PU_OFF_RES_CALC: rd_mux = div_quo[31:0];
	`PU_OFF_IRQ_STAT: rd_mux = {29'h0, irq_stat_q};
	`PU_OFF_IRQ_MASK: rd_mux = {29'h0, irq_mask_q};
	default:          rd_mux = 32'h0;
	endcase
end

endmodule

// file: hw/pucfg_defs.vh
// constants of the position-unit resolution configuration block
`ifndef PUCFG_DEFS_VH
`define PUCFG_DEFS_VH

// register byte offsets
`define PU_OFF_CTRL      8'h00
`define PU_OFF_UNIT      8'h04
`define PU_OFF_RES_NUM   8'h08
`define PU_OFF_RES_DEN   8'h0c
`define PU_OFF_GEAR_NUM  8'h10
`define PU_OFF_GEAR_DEN  8'h14
`define PU_OFF_DIR       8'h18
`define PU_OFF_STATUS    8'h1c
`define PU_OFF_RES_ACT   8'h20
`define PU_OFF_RES_CALC  8'h24
`define PU_OFF_IRQ_STAT  8'h28
`define PU_OFF_IRQ_MASK  8'h2c

// control bits (write one to trigger)
`define PU_CTRL_CONFIG   0
`define PU_CTRL_ALM_CLR  1
// direction bits
`define PU_DIR_MOTOR     0
`define PU_DIR_GEAR      1
// status bits
`define PU_ST_INFO       0
`define PU_ST_ALARM      1
`define PU_ST_BUSY       2
`define PU_ST_DIR        3
`define PU_ST_APPLY_PEND 4
// interrupt status bits
`define PU_IRQ_INFO      0
`define PU_IRQ_ALARM     1
`define PU_IRQ_APPLIED   2
`define PU_IRQ_W         3

// unit selection codes
`define PU_UNIT_ENC      8'd0
`define PU_UNIT_STEP     8'd1
`define PU_UNIT_MECH1    8'd10
`define PU_UNIT_MECH4    8'd13
`define PU_UNIT_REV3     8'd23
`define PU_UNIT_REV6     8'd26
`define PU_UNIT_DEG1     8'd31
`define PU_UNIT_DEG4     8'd34

// resolution limits and reset values
`define PU_RES_MIN       40'd500
`define PU_RES_MAX       40'd36000
`define PU_RST_RES       16'd36000
`define PU_RST_DEN       16'd1
`define PU_RST_UNIT      8'd0
`define PU_DEG_TURN      24'd360

// divider
`define PU_DIV_STEPS     6'd40

`endif

// file: hw/pucfg_div.v
// sequential restoring divider, 40-bit dividend by 16-bit divisor
`timescale 1ns/1ps
module pucfg_div (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        start,
	input  wire [39:0] dividend,
	input  wire [15:0] divisor,
	output wire        busy,
	output wire [39:0] quotient
);
`include "pucfg_defs.vh"

reg  [16:0] rem_q;
reg  [39:0] quo_q;
reg  [5:0]  cnt_q;
reg         busy_q;
wire [16:0] trial;

assign trial    = {rem_q[15:0], quo_q[39]};
assign busy     = busy_q;
assign quotient = quo_q;

//////////////////////////////////////////////////////////////////////
// one quotient bit per cycle
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		rem_q  <= 17'h0;
		quo_q  <= 40'h0;
		cnt_q  <= 6'h0;
		busy_q <= 1'b0;
	end else if (start) begin
		rem_q  <= 17'h0;
		quo_q  <= dividend;
		cnt_q  <= `PU_DIV_STEPS;
		busy_q <= 1'b1;
	end else if (busy_q) begin
		if (trial >= {1'b0, divisor}) begin
			rem_q <= trial - {1'b0, divisor};
			quo_q <= {quo_q[38:0], 1'b1};
		end else begin
			rem_q <= trial;
			quo_q <= {quo_q[38:0], 1'b0};
		end
		cnt_q  <= cnt_q - 6'h1;
		busy_q <= (cnt_q != 6'h1);
	end
end

endmodule

// file: verification/pucfg_checker.sv
// assertion checker bound to the position-unit configuration top
`timescale 1ns/1ps
module pucfg_checker (
	input logic        hclk,
	input logic        hresetn,
	input logic        hsel,
	input logic [7:0]  haddr,
	input logic [1:0]  htrans,
	input logic        hwrite,
	input logic [31:0] hwdata,
	input logic        hreadyout,
	input logic        hresp,
	input logic [15:0] active_res,
	input logic        positive_direction_ccw,
	input logic        unit_info,
	input logic        unit_alarm
);
	logic wr_q;
	logic ctl_q;
	// data-phase markers of any write and of a control write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'h0;
			ctl_q <= 1'h0;
		end else begin
			wr_q <= hsel && htrans[1] && hwrite && hreadyout;
			ctl_q <= hsel && htrans[1] && hwrite && hreadyout && haddr == 8'h00;
		end
	end
	////////////////////////////////////////
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_cfg_bad;
		ctl_q && hwdata[0] && unit_info;
	endsequence
	sequence s_alarm_up;
		##[1:100] unit_alarm;
	endsequence
	property p_bus; hreadyout && !hresp; endproperty
	property p_range; active_res >= 16'h1f4 && active_res <= 16'h8ca0; endproperty
	property p_cfg_bad; s_cfg_bad |-> s_alarm_up; endproperty
	property p_alarm_cause; $rose(unit_alarm) |-> $past(unit_info); endproperty
	property p_alarm_keep; $rose(unit_alarm) |-> $stable(active_res); endproperty
	property p_res_apply; !$stable(active_res) |-> !$past(unit_info); endproperty
	property p_dir_apply; !$stable(positive_direction_ccw) |-> !$past(unit_info); endproperty
	property p_info_src; !$stable(unit_info) |-> $past(wr_q); endproperty
	property p_alarm_clr; $fell(unit_alarm) |-> $past(ctl_q && hwdata[1]); endproperty
	a_bus: assert property (p_bus) else $error("bus answer not ready or okay");
	a_range: assert property (p_range) else $error("resolution out of range");
	a_cfg_bad: assert property (p_cfg_bad) else $error("no alarm after bad configure");
	a_alarm_cause: assert property (p_alarm_cause) else $error("alarm without info");
	a_alarm_keep: assert property (p_alarm_keep) else $error("resolution moved on alarm");
	a_res_apply: assert property (p_res_apply) else $error("bad resolution applied");
	a_dir_apply: assert property (p_dir_apply) else $error("direction applied while info");
	a_info_src: assert property (p_info_src) else $error("info moved without write");
	a_alarm_clr: assert property (p_alarm_clr) else $error("alarm dropped by itself");
endmodule
bind pucfg_top pucfg_checker pucfg_checker_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hreadyout, .hresp, .active_res, .positive_direction_ccw, .unit_info, .unit_alarm);

// file: verification/tb.sv
// self-checking bench for the position-unit configuration block
`timescale 1ns/1ps
module tb;
	logic        hclk = 1'h0;
	logic        hresetn = 1'h0;
	logic        hsel = 1'h0;
	logic [7:0]  haddr = 8'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd, r;
	logic [15:0] active_res;
	logic        hreadyout, hresp, ccw, unit_info, unit_alarm, irq, inf;
	logic        eccw = 1'h0;
	// mechanism attached with a fixed in-range base, so power-up keeps the default resolution
	logic        mech_pin = 1'h1;
	logic [23:0] mech_val = 24'h8ca0;
	integer      err_count = 0, num_checks = 0, seed = 95, j, k, n;
	longint      num, den, res = 36000;
	logic [7:0]  codes [10] = '{8'h17, 8'h18, 8'h19, 8'h1a, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h05, 8'h0b};
	logic [15:0] tp [8] = '{16'he10, 16'h1f4, 16'h1f3, 16'h8ca0, 16'h8ca1, 16'h3e9, 16'h3e7, 16'h64};
	logic [15:0] tq [8] = '{16'h1, 16'h1, 16'h1, 16'h1, 16'h1, 16'h2, 16'h2, 16'h0};
	always #20 hclk = ~hclk;
	pucfg_top pucfg_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .mech_present(mech_pin), .mech_res(mech_val),
		.active_res, .positive_direction_ccw(ccw), .unit_info, .unit_alarm, .irq);
	////////////////////////////////////////
	task close_out;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task edge_rdy;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'h1 && n < 50);
		if (hreadyout !== 1'h1) begin
			err_count++;
			close_out;
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		edge_rdy;
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		edge_rdy;
		rd = hrdata;
	endtask
	// poll until neither busy nor apply pending
	task settle;
		for (k = 0; k < 80; k++) begin
			bus(1'h0, 8'h1c, 32'h0);
			if ((rd & 32'h14) == 32'h0)
				break;
		end
		if (k == 80) begin
			err_count++;
			close_out;
		end
	endtask
	task cfg(input logic [7:0] u, input logic [15:0] p, input logic [15:0] q, input logic [1:0] dv);
		bus(1'h1, 8'h04, {24'h0, u});
		bus(1'h1, u == 8'h01 ? 8'h08 : 8'h10, {16'h0, p});
		bus(1'h1, u == 8'h01 ? 8'h0c : 8'h14, {16'h0, q});
		bus(1'h1, 8'h18, {30'h0, dv});
		if (u == 8'h01) begin
			num = p;
			den = q;
		end else begin
			num = q * (u < 8'd14 ? mech_val : u < 8'd30 ? 10 ** (u - 20) : 360 * 10 ** (u - 30));
			den = (u inside {8'h00, [10:13], [23:26], [31:34]}) ? p : 0;
		end
		inf = den == 0 || num < 500 * den || num > 36000 * den;
		settle;
		chk("info", unit_info, inf);
		chk("held", active_res, res);
		bus(1'h1, 8'h00, 32'h1);
		settle;
		if (!inf) begin
			res = num / den;
			eccw = u == 8'h01 ? dv[0] : ^dv;
		end
		chk("alarm", unit_alarm, inf);
		chk("res", active_res, res);
		chk("dir", ccw, eccw);
		bus(1'h0, 8'h20, 32'h0);
		chk("res_reg", rd, res);
		bus(1'h1, 8'h00, 32'h2);
		bus(1'h0, 8'h1c, 32'h0);
		chk("alarm_clr", rd[1], 1'h0);
	endtask
	////////////////////////////////////////
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'h1;
		settle;
		chk("res0", active_res, 32'h8ca0);
		chk("dir0", ccw, 1'h0);
		bus(1'h0, 8'h04, 32'h0);
		chk("unit0", rd, 32'h0);
		bus(1'h0, 8'h08, 32'h0);
		chk("num0", rd, 32'h8ca0);
		bus(1'h0, 8'h30, 32'h0);
		chk("gap", rd, 32'h0);
		for (j = 0; j < 8; j++)
			cfg(8'h01, tp[j], tq[j], j[1:0] ^ 2'h1);
		cfg(8'h18, 16'ha, 16'h1, 2'h2);
		cfg(8'h00, 16'h18, 16'h1, 2'h3);
		cfg(8'h0a, 16'h4, 16'h1, 2'h1);
		for (j = 0; j < 24; j++) begin
			r = $random(seed);
			cfg(j < 4 ? 8'h01 : codes[j % 10], j < 4 ? r[15:0] : {6'h0, r[9:0]} + 16'h1,
				{14'h0, r[17:16]} + 16'h1, r[21:20]);
		end
		bus(1'h0, 8'h28, 32'h0);
		chk("irq_st", rd[2:0], 3'h7);
		bus(1'h1, 8'h2c, 32'h4);
		bus(1'h0, 8'h2c, 32'h0);
		chk("mask", rd, 32'h4);
		chk("irq_on", irq, 1'h1);
		bus(1'h1, 8'h28, 32'h7);
		bus(1'h0, 8'h28, 32'h0);
		chk("irq_clr", rd, 32'h0);
		chk("irq_off", irq, 1'h0);
		close_out;
	end
endmodule
